//--- verilog/trs_consts.svh
`ifndef TRS_CONSTS_SVH
`define TRS_CONSTS_SVH

// system clock rate and the length of one delay tick
`define TRS_CLK_MHZ 40
`define TRS_TICK_US 1000

// sequence delays, in milliseconds
`define TRS_CTX_MS 10
`define TRS_CKY_MS 2
`define TRS_EMIT_MS 7
`define TRS_STOP_MS 7
`define TRS_UNMUTE_MS 12

// radiator thresholds, in degrees C
`define TRS_FAN_ON_C 8'h32
`define TRS_FAN_OFF_C 8'h2d
`define TRS_PROT_ON_C 8'h50
`define TRS_PROT_OFF_C 8'h46

// counter widths, reset values and increments
`define TRS_PRE_W 16
`define TRS_MS_W 8
`define TRS_PRE_ZERO 16'h0000
`define TRS_MS_ZERO 8'h00
`define TRS_PRE_ONE 16'h0001
`define TRS_MS_ONE 8'h01

`endif

//--- verilog/trs_pkg.sv
`include "trs_consts.svh"

package trs_pkg;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    TRS_RX     = 8'h01,
    TRS_PRE    = 8'h02,
    TRS_BLOCK  = 8'h04,
    TRS_SUP    = 8'h08,
    TRS_KEY    = 8'h10,
    TRS_EMIT   = 8'h20,
    TRS_STOP   = 8'h40,
    TRS_UNMUTE = 8'h80
  } trs_state_e;

  // keying style chosen by the operator
  typedef enum logic [1:0] {
    TRS_MANUAL = 2'h0,
    TRS_SEMI   = 2'h1,
    TRS_FULL   = 2'h2
  } trs_mode_e;

  typedef logic [`TRS_PRE_W-1:0] trs_pre_t;
  typedef logic [`TRS_MS_W-1:0] trs_ms_t;

  // supply and control lines toward the rf stages
  typedef struct packed {
    logic txControl;
    logic txSupply8v;
    logic txSupply13v8;
    logic rxSupply8v;
    logic keyControl;
    logic keyingSupply;
    logic rxUnmute;
    logic txEmit;
  } trs_supply_s;

  // whole state of the sequencer
  typedef struct packed {
    trs_state_e state;
    trs_pre_t seqPre;
    trs_ms_t seqMs;
    trs_pre_t holdPre;
    trs_ms_t holdMs;
    logic semiHold;
    logic standbySenseN;
    logic sharedKeyLine;
    logic fanOn;
    logic tempProtect;
    trs_supply_s sup;
  } trs_regs_s;

endpackage : trs_pkg

//--- verilog/trs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.svh"

// Notes on behaviour
// - on request, if frequency allowed, raise txControl 10 ms after the fall.
// - while txControl is high both transmit supplies are on.
// - keyControl rises 2 ms after the 8 V transmit supply; it drives keyingSupply.
// - transmit output starts 7 ms after the keying supply is enabled.
// - request released: output stops 7 ms later, transmit supplies off, receive on.
// - receive stays muted until 12 ms after the receive supply returns.
// - manual keying: the key itself drives keyingSupply.
// - semi break-in: key holds request low until operator delay after release.
// - semi break-in: key also drives sharedKeyLine, one clock before the sense line falls.
// - full break-in: key pulls standbySenseN low like the standby switch.
// - full break-in: keyingSupply follows keyControl only.
// - fan on at 50 C, off at 45 C.
// - protection on at 80 C, off at 70 C; reduces power, stays transmitting.
module trs_sequencer
  import trs_pkg::*;
#(
  parameter int TICK_CYCLES = `TRS_CLK_MHZ * `TRS_TICK_US
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // operator side
  input wire logic standbyRequestN,
  input wire logic keyDown,
  input wire trs_mode_e keyMode,
  input wire trs_ms_t semiDelayMs,
  input wire logic txAllowed,
  input wire logic [7:0] radiatorTemp,
  // rf stage side
  output var trs_supply_s supplyOut,
  output logic standbySenseN,
  output logic sharedKeyLine,
  output logic fanOn,
  output logic tempProtect
);

  // delay end points: a step fires on the tick that completes its last millisecond
  localparam trs_pre_t TICK_LAST = trs_pre_t'(TICK_CYCLES - 1);
  localparam int CTX_LAST = `TRS_CTX_MS - 1;
  localparam int CKY_LAST = `TRS_CKY_MS - 1;
  localparam int EMIT_LAST = `TRS_EMIT_MS - 1;
  localparam int STOP_LAST = `TRS_STOP_MS - 1;
  localparam int UNMUTE_LAST = `TRS_UNMUTE_MS - 1;

  // all sequencer state lives in one register word
  trs_regs_s r_reg;
  trs_regs_s r_next;
  logic seqTick;
  logic holdTick;
  logic reqLow;

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    r_next = r_reg;
    seqTick = (r_reg.seqPre == TICK_LAST);
    holdTick = (r_reg.holdPre == TICK_LAST);

    // fixed 1 ms tick for the sequence delays
    r_next.seqPre = seqTick ? `TRS_PRE_ZERO : r_reg.seqPre + `TRS_PRE_ONE;
    if (seqTick) begin
      r_next.seqMs = r_reg.seqMs + `TRS_MS_ONE;
    end

    // semi break-in one-shot, retriggered while the key is down
    // holdMs stops at the operator delay, so the hang time is fixed after release
    if (keyMode == TRS_SEMI && keyDown) begin
      r_next.semiHold = 1'b1;
      r_next.holdPre = `TRS_PRE_ZERO;
      r_next.holdMs = `TRS_MS_ZERO;
    end else if (r_reg.semiHold) begin
      r_next.holdPre = holdTick ? `TRS_PRE_ZERO : r_reg.holdPre + `TRS_PRE_ONE;
      if (r_reg.holdMs >= semiDelayMs) begin
        r_next.semiHold = 1'b0;
      end else if (holdTick) begin
        r_next.holdMs = r_reg.holdMs + `TRS_MS_ONE;
      end
    end

    // all request sources merge onto one sense line
    // registered before use, so a key bounce cannot split the state machine's view
    reqLow = !standbyRequestN || r_reg.semiHold || (keyMode == TRS_FULL && keyDown);
    r_next.standbySenseN = !reqLow;

    // transmit/receive sequence, driven from the registered sense line
    case (r_reg.state)
      TRS_RX: begin
        if (!r_reg.standbySenseN) begin
          r_next.state = txAllowed ? TRS_PRE : TRS_BLOCK;
        end
      end
      TRS_PRE: begin
        if (r_reg.standbySenseN) begin
          r_next.state = TRS_RX;
        end else if (seqTick && r_reg.seqMs == trs_ms_t'(CTX_LAST)) begin
          r_next.state = TRS_SUP;
          r_next.sup.txControl = 1'b1;
          r_next.sup.txSupply8v = 1'b1;
          r_next.sup.txSupply13v8 = 1'b1;
          r_next.sup.rxSupply8v = 1'b0;
          r_next.sup.rxUnmute = 1'b0;
        end
      end
      TRS_BLOCK: begin
        // receive supplies untouched while the frequency is refused
        if (r_reg.standbySenseN) begin
          r_next.state = TRS_RX;
        end
      end
      TRS_SUP: begin
        if (r_reg.standbySenseN) begin
          r_next.state = TRS_STOP;
        end else if (seqTick && r_reg.seqMs == trs_ms_t'(CKY_LAST)) begin
          r_next.state = TRS_KEY;
          r_next.sup.keyControl = 1'b1;
        end
      end
      TRS_KEY: begin
        if (r_reg.standbySenseN) begin
          r_next.state = TRS_STOP;
        end else if (seqTick && r_reg.seqMs == trs_ms_t'(EMIT_LAST)) begin
          r_next.state = TRS_EMIT;
          r_next.sup.txEmit = 1'b1;
        end
      end
      TRS_EMIT: begin
        if (r_reg.standbySenseN) begin
          r_next.state = TRS_STOP;
        end
      end
      TRS_STOP: begin
        // a renewed request here is served after the receive switch-over
        if (seqTick && r_reg.seqMs == trs_ms_t'(STOP_LAST)) begin
          r_next.state = TRS_UNMUTE;
          r_next.sup.txEmit = 1'b0;
          r_next.sup.keyControl = 1'b0;
          r_next.sup.txControl = 1'b0;
          r_next.sup.txSupply8v = 1'b0;
          r_next.sup.txSupply13v8 = 1'b0;
          r_next.sup.rxSupply8v = 1'b1;
        end
      end
      TRS_UNMUTE: begin
        if (!r_reg.standbySenseN) begin
          r_next.state = TRS_RX;
        end else if (seqTick && r_reg.seqMs == trs_ms_t'(UNMUTE_LAST)) begin
          r_next.state = TRS_RX;
          r_next.sup.rxUnmute = 1'b1;
        end
      end
      default: begin
        r_next.state = TRS_RX;
      end
    endcase

    // every state change restarts the delay count
    // a fresh count per state means an aborted step never leaves a short delay behind
    if (r_next.state != r_reg.state) begin
      r_next.seqPre = `TRS_PRE_ZERO;
      r_next.seqMs = `TRS_MS_ZERO;
    end

    // keying path depends on the break-in style
    case (keyMode)
      TRS_FULL: r_next.sup.keyingSupply = r_next.sup.keyControl;
      default: r_next.sup.keyingSupply = keyDown && r_next.sup.keyControl;
    endcase
    r_next.sharedKeyLine = (keyMode == TRS_SEMI) && keyDown;

    // thermal hysteresis; protection only lowers power
    // the gap between on and off levels keeps the fan from chattering at one reading
    if (radiatorTemp >= `TRS_FAN_ON_C) begin
      r_next.fanOn = 1'b1;
    end else if (radiatorTemp <= `TRS_FAN_OFF_C) begin
      r_next.fanOn = 1'b0;
    end
    if (radiatorTemp >= `TRS_PROT_ON_C) begin
      r_next.tempProtect = 1'b1;
    end else if (radiatorTemp <= `TRS_PROT_OFF_C) begin
      r_next.tempProtect = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // reset lands in receive with the receiver live, as after power-up
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.state <= TRS_RX;
      r_reg.standbySenseN <= 1'b1;
      r_reg.sup.rxSupply8v <= 1'b1;
      r_reg.sup.rxUnmute <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state flops
  assign supplyOut = r_reg.sup;
  assign standbySenseN = r_reg.standbySenseN;
  assign sharedKeyLine = r_reg.sharedKeyLine;
  assign fanOn = r_reg.fanOn;
  assign tempProtect = r_reg.tempProtect;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // sequence steps, each checked against the delay count that led to it, and both transmit supplies held under txControl

  a_ctx_delay: assert property ($rose(supplyOut.txControl) |->
    $past(r_reg.state) == TRS_PRE && $past(r_reg.seqMs) == trs_ms_t'(CTX_LAST))
    else $error("txControl rose at wrong time");
  a_tx_supplies: assert property (supplyOut.txControl |->
    supplyOut.txSupply8v && supplyOut.txSupply13v8)
    else $error("transmit supplies off while txControl high");
  a_cky_delay: assert property ($rose(supplyOut.keyControl) |->
    $past(supplyOut.txSupply8v) && $past(r_reg.seqMs) == trs_ms_t'(CKY_LAST))
    else $error("keyControl rose at wrong time");
  a_emit_delay: assert property ($rose(supplyOut.txEmit) |->
    supplyOut.keyControl && $past(r_reg.seqMs) == trs_ms_t'(EMIT_LAST))
    else $error("transmit output started at wrong time");
  a_stop_swap: assert property ($fell(supplyOut.txSupply8v) |->
    supplyOut.rxSupply8v && !supplyOut.txSupply13v8 && !supplyOut.txEmit
    && $past(r_reg.seqMs) == trs_ms_t'(STOP_LAST))
    else $error("receive switch-over wrong");
  a_unmute_delay: assert property ($rose(supplyOut.rxUnmute) |->
    supplyOut.rxSupply8v && $past(r_reg.seqMs) == trs_ms_t'(UNMUTE_LAST))
    else $error("unmute at wrong time");

  // break-in styles: who pulls the sense line and who drives the keying stage
  a_full_sense: assert property (keyMode == TRS_FULL && keyDown |=> !standbySenseN)
    else $error("full break-in key did not pull sense low");
  a_semi_hold: assert property (keyMode == TRS_SEMI && keyDown |=> ##1 !standbySenseN)
    else $error("semi break-in key did not hold sense low");
  a_semi_line: assert property (keyMode == TRS_SEMI |=> sharedKeyLine == $past(keyDown))
    else $error("shared key line does not track key");
  a_full_keying: assert property ($past(keyMode) == TRS_FULL |->
    supplyOut.keyingSupply == supplyOut.keyControl)
    else $error("full break-in keying not from keyControl");
  a_manual_key: assert property (keyMode == TRS_MANUAL && !keyDown |=> !supplyOut.keyingSupply)
    else $error("manual keying without key closure");

  // thermal flags may only move at their own thresholds, and a refused frequency keeps the receive supplies
  a_fan_hyst: assert property ($changed(fanOn) |->
    fanOn ? $past(radiatorTemp) >= `TRS_FAN_ON_C : $past(radiatorTemp) <= `TRS_FAN_OFF_C)
    else $error("fan switched outside thresholds");
  a_prot_hyst: assert property ($changed(tempProtect) |->
    tempProtect ? $past(radiatorTemp) >= `TRS_PROT_ON_C : $past(radiatorTemp) <= `TRS_PROT_OFF_C)
    else $error("protection switched outside thresholds");
  a_block_rx: assert property (r_reg.state == TRS_BLOCK |->
    !supplyOut.txControl && supplyOut.rxSupply8v && !supplyOut.txSupply8v)
    else $error("refused frequency left receive state");

  // supply interlocks: the two 8 V lines never overlap, and the receiver stays muted while keyed
  a_rx_tx_apart: assert property (supplyOut.rxSupply8v |-> !supplyOut.txSupply8v)
    else $error("receive and transmit supplies on together");
  a_mute_in_tx: assert property (supplyOut.txControl |-> !supplyOut.rxUnmute)
    else $error("receiver unmuted during transmit");

  // refused frequency: a request seen in receive must park the sequencer
  a_block_entry: assert property (r_reg.state == TRS_RX && !r_reg.standbySenseN && !txAllowed |=>
    r_reg.state == TRS_BLOCK)
    else $error("refused request not parked");

  // request merging, the semi break-in one-shot and the shared key line outside semi break-in
  a_sense_merge: assert property (!standbyRequestN |=> !standbySenseN)
    else $error("standby request not merged onto sense line");
  a_semi_release: assert property ($fell(r_reg.semiHold) |->
    $past(r_reg.holdMs) >= $past(semiDelayMs))
    else $error("semi hold released before its delay");
  a_shared_idle: assert property (keyMode != TRS_SEMI |=> !sharedKeyLine)
    else $error("shared key line active outside semi break-in");

  // thermal protection only lowers power, it never ends a transmission
  a_prot_no_rx: assert property (tempProtect && r_reg.state == TRS_EMIT && !r_reg.standbySenseN |=>
    r_reg.state == TRS_EMIT && supplyOut.txEmit)
    else $error("protection forced a return to receive");

  // every state change must start its delay from zero, or the next step comes early
  a_count_restart: assert property ($changed(r_reg.state) |->
    r_reg.seqMs == `TRS_MS_ZERO && r_reg.seqPre == `TRS_PRE_ZERO)
    else $error("delay count not restarted on state change");

  // main scenarios that the bench should reach
  c_full_tx: cover property ($rose(supplyOut.txEmit));
  c_back_rx: cover property ($rose(supplyOut.rxUnmute));
  c_blocked: cover property (r_reg.state == TRS_BLOCK);
  c_semi: cover property ($fell(r_reg.semiHold));
  c_hot_tx: cover property (tempProtect && supplyOut.txEmit);

endmodule : trs_sequencer

`default_nettype wire

//--- dv/trs_rf_partner.sv
`timescale 1ns/1ps
`default_nettype none

// operator side of the radio: standby switch, push-to-talk and key
module trs_rf_partner
  import trs_pkg::*;
(
  // operator controls
  input wire logic switchOn,
  input wire logic pttOn,
  input wire logic keyClosed,
  // toward the sequencer
  output logic standbyRequestN,
  output logic keyDown
);
  // both switches pull the one shared request line low, like an open collector
  assign standbyRequestN = ~(switchOn | pttOn);
  // the key contact goes straight to the sequencer, which merges it per mode
  assign keyDown = keyClosed;
endmodule : trs_rf_partner

`default_nettype wire

//--- dv/tx_rx_standby_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tx_rx_standby_sequencer_tb
  import trs_pkg::*;
;
  localparam int TK = 8; // short tick keeps the run small
  typedef struct packed {logic [7:0] t; logic fan; logic prot;} trs_trow_s;
  logic clk_sys, reset, standbyRequestN, keyDown, txAllowed, switchOn, pttOn, keyClosed;
  logic standbySenseN, sharedKeyLine, fanOn, tempProtect;
  trs_mode_e keyMode;
  trs_ms_t semiDelayMs;
  logic [7:0] radiatorTemp;
  trs_supply_s supplyOut;
  int errCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int n;
  trs_trow_s rows [8] = '{'{8'h31, 1'b0, 1'b0}, '{8'h32, 1'b1, 1'b0}, '{8'h2e, 1'b1, 1'b0},
    '{8'h2d, 1'b0, 1'b0}, '{8'h50, 1'b1, 1'b1}, '{8'h47, 1'b1, 1'b1}, '{8'h46, 1'b1, 1'b0},
    '{8'h2d, 1'b0, 1'b0}};

  trs_sequencer #(.TICK_CYCLES(TK)) u_dut (.clk_sys(clk_sys), .reset(reset),
    .standbyRequestN(standbyRequestN), .keyDown(keyDown), .keyMode(keyMode),
    .semiDelayMs(semiDelayMs), .txAllowed(txAllowed), .radiatorTemp(radiatorTemp),
    .supplyOut(supplyOut), .standbySenseN(standbySenseN), .sharedKeyLine(sharedKeyLine),
    .fanOn(fanOn), .tempProtect(tempProtect));
  trs_rf_partner u_partner (.switchOn(switchOn), .pttOn(pttOn), .keyClosed(keyClosed),
    .standbyRequestN(standbyRequestN), .keyDown(keyDown));

  //////////////////////////////////////////////////////////////////////////////
  // 40 mhz clock and a cycle ceiling well above the roughly 900 cycles needed
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errCount++;
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // comparison, bounded wait and closing report
  task automatic chk(input logic ok, input string msg);
    samplesChecked++;
    if (ok !== 1'b1) begin
      errCount++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk

  // counts falling edges until the picked output reaches lvl; a hang is a mismatch
  task automatic wait_ev(input int sel, input logic lvl, output int cnt);
    logic v;
    cnt = 0;
    do begin
      @(negedge clk_sys);
      cnt++;
      case (sel)
        0: v = supplyOut.txControl;
        1: v = supplyOut.keyControl;
        2: v = supplyOut.txEmit;
        3: v = standbySenseN;
        4: v = supplyOut.rxUnmute;
        default: v = supplyOut.rxSupply8v;
      endcase
    end while (v !== lvl && cnt < 2000);
    chk(cnt < 2000, "output never reached its level");
  endtask : wait_ev

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset = 1'b1;
    switchOn = 1'b0;
    pttOn = 1'b0;
    keyClosed = 1'b0;
    txAllowed = 1'b1;
    keyMode = TRS_MANUAL;
    semiDelayMs = 8'h02;
    radiatorTemp = 8'h19;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    chk(supplyOut === 8'h12 && standbySenseN === 1'b1 && fanOn === 1'b0, "reset state wrong");
    $display("test reset done");
    // thermal thresholds with hysteresis, one edge of latency
    foreach (rows[i]) begin
      radiatorTemp = rows[i].t;
      @(negedge clk_sys);
      chk(fanOn === rows[i].fan, "fan level wrong");
      chk(tempProtect === rows[i].prot, "protection level wrong");
    end
    $display("test thermal done");
    // manual keying, full transmit and return cycle
    keyClosed = 1'b1;
    switchOn = 1'b1;
    wait_ev(3, 1'b0, n);
    wait_ev(0, 1'b1, n);
    chk(n == 10 * TK + 1, "transmit control delay wrong");
    chk(supplyOut[6:4] === 3'b110 && supplyOut.rxUnmute === 1'b0, "supplies not switched");
    wait_ev(1, 1'b1, n);
    chk(n == 2 * TK && supplyOut.keyingSupply === 1'b1, "key control delay wrong");
    wait_ev(2, 1'b1, n);
    chk(n == 7 * TK, "emit delay wrong");
    keyClosed = 1'b0;
    radiatorTemp = 8'h55;
    repeat (2) @(negedge clk_sys);
    chk(supplyOut.keyingSupply === 1'b0, "keying ignores key in manual mode");
    chk(tempProtect === 1'b1 && supplyOut.txEmit === 1'b1, "protection dropped transmit");
    radiatorTemp = 8'h19;
    switchOn = 1'b0;
    wait_ev(3, 1'b1, n);
    wait_ev(2, 1'b0, n);
    chk(n == 7 * TK + 1, "stop delay wrong");
    chk(supplyOut[6:4] === 3'b001, "receive supplies not restored");
    wait_ev(4, 1'b1, n);
    chk(n == 12 * TK, "unmute delay wrong");
    $display("test manual done");
    // forbidden frequency through push-to-talk: stays in receive
    txAllowed = 1'b0;
    pttOn = 1'b1;
    repeat (12 * TK) @(negedge clk_sys);
    chk(supplyOut === 8'h12, "blocked request changed supplies");
    pttOn = 1'b0;
    txAllowed = 1'b1;
    repeat (4) @(negedge clk_sys);
    $display("test blocked done");
    // semi break-in: one-shot hold, then release inside the pre-wait
    keyMode = TRS_SEMI;
    keyClosed = 1'b1;
    wait_ev(3, 1'b0, n);
    chk(n <= 3 && sharedKeyLine === 1'b1, "semi key did not hold request");
    keyClosed = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(sharedKeyLine === 1'b0 && standbySenseN === 1'b0, "semi hold or key copy wrong");
    wait_ev(3, 1'b1, n);
    chk(n >= 2 * TK - 2 && n <= 2 * TK + 2, "semi hang time wrong");
    repeat (4) @(negedge clk_sys);
    chk(supplyOut === 8'h12, "short request toggled supplies");
    $display("test semi done");
    // full break-in: key acts as standby switch, keying follows key control only
    keyMode = TRS_FULL;
    keyClosed = 1'b1;
    wait_ev(3, 1'b0, n);
    chk(n <= 3, "full break-in key did not pull request");
    switchOn = 1'b1;
    keyClosed = 1'b0;
    wait_ev(1, 1'b1, n);
    chk(supplyOut.keyingSupply === 1'b1, "keying not from key control");
    switchOn = 1'b0;
    wait_ev(4, 1'b1, n);
    $display("test full done");
    // reset in mid-sequence returns straight to receive
    keyMode = TRS_MANUAL;
    switchOn = 1'b1;
    wait_ev(0, 1'b1, n);
    reset = 1'b1;
    @(negedge clk_sys);
    chk(supplyOut === 8'h12 && standbySenseN === 1'b1, "mid-run reset state wrong");
    // release with the switch still on: the sequence must start over from scratch
    reset = 1'b0;
    @(negedge clk_sys);
    chk(supplyOut === 8'h12 && standbySenseN === 1'b0, "request lost over reset");
    wait_ev(0, 1'b1, n);
    chk(n == 10 * TK + 1, "restart delay wrong");
    $display("test reset again done");
    finish_test();
  end
endmodule : tx_rx_standby_sequencer_tb

`default_nettype wire
